// [sal_lock_properties.sv]
// assertions on the display outputs of the setup access lock
// assumes it is bound to sal_setup_access_lock
`timescale 1ns/1ps
module sal_lock_properties
    import sal_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and total reset
    input wire logic pclk,
    input wire logic presetn,
    // display
    input wire logic [1:0] menu_loop,
    input wire logic [4:0] setup_item,
    input wire logic [3:0] frame_count,
    input wire logic show_ok,
    input wire logic setup_access,
    input wire logic transport_state
);
    // timeout plus one tick of phase slack
    localparam int TO_CYC = (TIMEOUT_TICKS + 1) * TICK_CYC + 4;
    logic [31:0] in_setup_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles spent in the setup menu
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            in_setup_reg <= 32'h0;
        else
            in_setup_reg <= (menu_loop == MENU_SETUP) ? in_setup_reg + 32'h1 : 32'h0;
    end
    sequence s_setup_exit;
        (menu_loop == MENU_SETUP) ##1 (menu_loop == MENU_USER);
    endsequence
    sequence s_finish_exit;
        (menu_loop == MENU_OK) ##1 (menu_loop == MENU_USER);
    endsequence
    property p_no_return;
        !$rose(transport_state);
    endproperty
    property p_enter_gate;
        (menu_loop == MENU_TECH) ##1 (menu_loop == MENU_SETUP) |-> $past(setup_access);
    endproperty
    property p_finish_lock;
        s_finish_exit |-> !transport_state && !setup_access;
    endproperty
    property p_op_exit_lock;
        s_setup_exit ##0 !transport_state |-> !setup_access;
    endproperty
    property p_ok_frames;
        menu_loop == MENU_OK |-> show_ok && frame_count == 4'h8;
    endproperty
    property p_ok_entry;
        $rose(menu_loop == MENU_OK) |-> $past(setup_item) == FINISH_ITEM;
    endproperty
    property p_timeout;
        in_setup_reg <= TO_CYC;
    endproperty
    property p_user_order;
        $past(menu_loop) == MENU_USER |-> menu_loop != MENU_SETUP;
    endproperty
    a_no_return: assert property (p_no_return) else $error("transport re-entered");
    a_enter_gate: assert property (p_enter_gate) else $error("setup entered locked");
    a_finish_lock: assert property (p_finish_lock) else $error("finish exit open");
    a_op_exit_lock: assert property (p_op_exit_lock) else $error("exit left access");
    a_ok_frames: assert property (p_ok_frames) else $error("ok frames wrong");
    a_ok_entry: assert property (p_ok_entry) else $error("ok off finish item");
    a_timeout: assert property (p_timeout) else $error("setup timeout late");
    a_user_order: assert property (p_user_order) else $error("user to setup jump");
endmodule // sal_lock_properties
bind sal_setup_access_lock sal_lock_properties #(.TICK_CYC(TICK_CYC)) u_props (
    .pclk(pclk),
    .presetn(presetn),
    .menu_loop(menu_loop),
    .setup_item(setup_item),
    .frame_count(frame_count),
    .show_ok(show_ok),
    .setup_access(setup_access),
    .transport_state(transport_state)
);

// [sal_panel_model.sv]
// technician at the front keys and the seal switch
// assumes tasks are called right after a rising pclk edge
`timescale 1ns/1ps
module sal_panel_model (
    // clock
    input wire logic pclk,
    // keys and seal switch
    output logic primary_key,
    output logic arrow_key,
    output logic seal_reassembled
);
    // keys idle released
    initial begin
        primary_key = 1'b0;
        arrow_key = 1'b0;
        seal_reassembled = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // hold the primary key n cycles, then release
    task automatic press(input int n);
        primary_key <= 1'b1;
        idle(n);
        primary_key <= 1'b0;
        idle(12);
    endtask
    // one arrow step
    task automatic step();
        arrow_key <= 1'b1;
        idle(6);
        arrow_key <= 1'b0;
        idle(6);
    endtask
    // long hold to the technician menu, then one tap
    task automatic enter();
        press(220);
        press(20);
    endtask
    // primary held while stepping leaves the menu
    task automatic leave();
        primary_key <= 1'b1;
        idle(8);
        arrow_key <= 1'b1;
        idle(8);
        arrow_key <= 1'b0;
        primary_key <= 1'b0;
        idle(12);
    endtask
    // seal broken, top and base reassembled
    task automatic seal_event();
        seal_reassembled <= 1'b1;
        idle(8);
        seal_reassembled <= 1'b0;
        idle(8);
    endtask
endmodule // sal_panel_model

// [sal_pkg.sv]
// constants, state encoding and register map of the setup access lock
// assumes a 200 MHz pclk and a 32-bit apb register bus
package sal_pkg;
    // clock and slow menu tick
    localparam int CLK_KHZ = 200000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
    // menu timing in its own units, then in ticks
    localparam int HOLD_S = 5;
    localparam int TIMEOUT_MIN = 4;
    localparam int HOLD_TICKS = HOLD_S * 1000 / TICK_MS;
    localparam int TIMEOUT_TICKS = TIMEOUT_MIN * 60 * 1000 / TICK_MS;
    // configuration limit and menu layout
    localparam logic [5:0] CFG_LIMIT = 6'h32;
    localparam logic [4:0] SETUP_LAST_ITEM = 5'h18;
    localparam logic [4:0] FINISH_ITEM = 5'h18;
    localparam logic [31:0] FLOW_PCT = 32'h00000001;
    localparam logic [31:0] PCT_SCALE = 32'h00000064;
    // module reading reference numbers and node id split
    localparam logic [5:0] REF_TYPE = 6'h1F;
    localparam logic [5:0] REF_LAST = 6'h24;
    localparam logic [5:0] REF_NODE0 = 6'h22;
    localparam logic [7:0] NET_MODULE_TYPE = 8'h3C;
    localparam logic [31:0] EMPTY_READING = 32'h00000000;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic [7:0] RATING_OFS = 8'h0C;
    localparam logic [7:0] RSEL_OFS = 8'h10;
    localparam logic [7:0] RVAL_OFS = 8'h14;
    localparam logic [7:0] RSTAT_OFS = 8'h18;
    // field positions
    localparam int CTRL_SAVE_BIT = 0;
    localparam int RSEL_REF_LSB = 0;
    localparam int RSEL_SLOT_LSB = 8;
    // reset values
    localparam logic [23:0] RATING_RST = 24'h0003E8;
    localparam logic [5:0] RSEL_REF_RST = 6'h1F;
    // menu loops
    typedef enum logic [1:0] {MENU_USER, MENU_TECH, MENU_SETUP, MENU_OK} sal_menu_e;
endpackage

// [sal_setup_access_lock.sv]
// front-key setup menu access control with module information readings
// assumes keys and seal switch are asynchronous pins, flow and module data
// arrive on pclk from the measurement logic, and presetn is the total reset
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - an empty slot reads its type and configuration value as 00000000.
// - readings of a module whose link is not working are flagged empty, not stale.
// - each module reading is selected by its fixed reference number, not its position.
// - for a networked-control module, references 34 to 36 show the three node id parts in decimal.
// - after 50 counted configurations the setup menu is locked.
// - that limit lock is lifted only by total reset.
// - in transport state the setup menu opens from the keys without any seal event.
// - transport state ends on flow of at least 1 percent of nominal rating or on the finish exit.
// - only total reset puts the device back into transport state.
// - in operation access opens only after a seal break and reassembly event.
// - holding the primary key while stepping with the arrow key leaves the setup menu.
// - after 4 minutes in the setup menu it times out to the first user reading.
// - holding the primary key 5 seconds on the finish item counts frames up, shows ok and locks.
// - in transport state key and timeout exits keep access, the finish exit locks it.
// - in operation every exit locks access until the next seal event.
module sal_setup_access_lock
    import sal_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and total reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // front keys and seal switch pins
    input wire logic primary_key,
    input wire logic arrow_key,
    input wire logic seal_reassembled,
    // flow measurement
    input wire logic [23:0] flow_rate,
    // mounted modules
    input wire logic [3:0] mod_present,
    input wire logic [3:0] mod_comm_ok,
    input wire logic [3:0][7:0] mod_type,
    input wire logic [3:0][5:0][31:0] mod_reading,
    input wire logic [3:0][47:0] mod_node_id,
    // display
    output logic [1:0] menu_loop,
    output logic [4:0] setup_item,
    output logic [3:0] frame_count,
    output logic show_ok,
    output logic setup_access,
    output logic transport_state
);
    // elaboration check: the hold counter is 7 bits and the timeout counter 12 bits,
    // and the finish animation needs at least one tick per frame
    if (TICK_CYC < 1 || HOLD_TICKS < 8 || TIMEOUT_TICKS > 4095) begin : g_chk
        $error("sal_setup_access_lock: unusable timing parameters");
    end

    // all state of the block; s1 and s2 are the pin synchronisers, dly holds
    // the previous synchronised level for edge detection, and only s2 and dly are read
    // by logic so a metastable s1 never reaches the decode
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] dly;
        logic [31:0] div;
        sal_menu_e menu;
        logic [4:0] item;
        logic [6:0] hold;
        logic [11:0] tmo;
        logic saved;
        logic transport;
        logic unlocked;
        logic [5:0] cfg_cnt;
        logic [23:0] rating;
        logic [1:0] sel_slot;
        logic [5:0] sel_ref;
        logic [31:0] rd_val;
        logic rd_empty;
        logic [31:0] prdata;
        logic pslverr;
    } sal_state_s;

    // registered state and its next value
    sal_state_s st_reg;
    sal_state_s st_next;

    // binary to five decimal digits by shift and add; five digits cover any
    // 16-bit part of a node id
    function automatic logic [19:0] to_bcd(input logic [15:0] bin);
        logic [19:0] bcd;
        bcd = 20'h00000;
        for (int i = 15; i >= 0; i--) begin
            for (int d = 0; d < 5; d++) begin
                if (bcd[d*4 +: 4] > 4'h4) begin
                    bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
                end
            end
            bcd = {bcd[18:0], bin[i]};
        end
        return bcd;
    endfunction

    // frame position of the finish animation, eight frames over the hold
    // the divisor is a constant, so this folds into a small table
    function automatic logic [3:0] frames(input logic [6:0] hold);
        logic [13:0] scaled;
        scaled = 14'({hold, 3'b000}) / 14'(HOLD_TICKS);
        return scaled[3:0];
    endfunction

    // strobes decoded once and shared by the next-state logic and the outputs
    logic prim;
    logic exit_keys;
    logic prim_fall;
    logic arrow_rise;
    logic seal_rise;
    logic tick;
    logic limit_locked;
    logic access_ok;
    logic hold_done;
    logic exit_any;
    logic exit_finish;
    logic flow_hit;
    logic wr_en;
    logic rd_setup;
    logic [2:0] ref_idx;
    logic [1:0] node_part;

    // key, seal and tick decode; the synchronisers reset to the released level
    // of the pins, so no false edge is seen when reset ends
    assign prim = st_reg.s2[0];
    assign exit_keys = prim && arrow_rise;
    assign prim_fall = ~prim & st_reg.dly[0];
    assign arrow_rise = st_reg.s2[1] & ~st_reg.dly[1];
    // one seal rising edge is one break and reassembly of the housing
    assign seal_rise = st_reg.s2[2] & ~st_reg.dly[2];
    // the menu tick is a one-cycle enable from the free-running divider
    assign tick = (st_reg.div == 32'(TICK_CYC - 1));
    assign hold_done = tick && prim && (st_reg.hold == 7'(HOLD_TICKS - 1));

    // access decision; the limit lock overrides both the transport path and
    // the seal path, so a later seal event cannot reopen a full counter
    assign limit_locked = (st_reg.cfg_cnt >= CFG_LIMIT);
    assign access_ok = !limit_locked && (st_reg.transport || st_reg.unlocked);
    assign flow_hit = (32'(flow_rate) * PCT_SCALE) >= (32'(st_reg.rating) * FLOW_PCT);

    // apb decode, answer always in the first access cycle
    // read data is loaded at the setup edge so it stands through the access cycle
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign ref_idx = 3'(st_reg.sel_ref - REF_TYPE);
    assign node_part = 2'(st_reg.sel_ref - REF_NODE0);

    // next state
    always_comb begin
        st_next = st_reg;
        exit_any = 1'b0;
        exit_finish = 1'b0;
        // synchroniser stages, edge history and tick divider
        st_next.s1 = {seal_reassembled, arrow_key, primary_key};
        st_next.s2 = st_reg.s1;
        st_next.dly = st_reg.s2;
        st_next.div = tick ? 32'h00000000 : st_reg.div + 32'h00000001;

        // primary hold time in ticks, saturating so a long hold cannot wrap
        if (!prim) begin
            st_next.hold = 7'h00;
        end else if (tick && st_reg.hold < 7'(HOLD_TICKS)) begin
            st_next.hold = st_reg.hold + 7'h01;
        end

        // menu walk; at most one exit is taken per cycle, the timeout first
        unique case (st_reg.menu)
            // user readings until a long primary hold
            MENU_USER: begin
                if (hold_done) begin
                    st_next.menu = MENU_TECH;
                end
            end

            // technician readings; a short tap enters setup, the release that
            // ends the long hold does not
            MENU_TECH: begin
                if (exit_keys) begin
                    st_next.menu = MENU_USER;
                end else if (prim_fall && st_reg.hold < 7'(HOLD_TICKS) && access_ok) begin
                    st_next.menu = MENU_SETUP;
                    st_next.item = 5'h00;
                    st_next.tmo = 12'h000;
                    st_next.saved = 1'b0;
                end
            end

            // setup items; the timeout runs from entry and key activity does
            // not restart it
            MENU_SETUP: begin
                if (tick) begin
                    st_next.tmo = st_reg.tmo + 12'h001;
                end

                if (tick && st_reg.tmo == 12'(TIMEOUT_TICKS - 1)) begin
                    exit_any = 1'b1;
                    st_next.menu = MENU_USER;
                end else if (exit_keys) begin
                    exit_any = 1'b1;
                    st_next.menu = MENU_USER;
                end else if (hold_done && st_reg.item == FINISH_ITEM) begin
                    exit_any = 1'b1;
                    exit_finish = 1'b1;
                    st_next.menu = MENU_OK;
                end else if (arrow_rise) begin
                    // stepping past the finish item wraps to the first item
                    st_next.item = (st_reg.item == SETUP_LAST_ITEM) ? 5'h00 :
                        st_reg.item + 5'h01;
                end
            end

            // ok shown until the primary key is released
            MENU_OK: begin
                if (!prim) begin
                    st_next.menu = MENU_USER;
                end
            end
        endcase
        // every return to the user readings starts at the first one
        if (st_next.menu == MENU_USER) begin
            st_next.item = 5'h00;
        end

        // change saved by the editing logic during this session
        // only a save made inside the setup menu counts towards the limit
        if (wr_en && paddr == CTRL_OFS && pwdata[CTRL_SAVE_BIT] &&
            st_reg.menu == MENU_SETUP) begin
            st_next.saved = 1'b1;
        end

        // exit effects on counter, transport and seal unlock
        // the counter stops at the limit, so it never wraps back to an open state
        if (exit_any) begin
            if (st_next.saved && !limit_locked) begin
                st_next.cfg_cnt = st_reg.cfg_cnt + 6'h01;
            end
            if (exit_finish) begin
                st_next.transport = 1'b0;
                st_next.unlocked = 1'b0;
            end else if (!st_reg.transport) begin
                st_next.unlocked = 1'b0;
            end
        end

        // a one-way step: flow that falls again cannot restore transport state
        if (st_reg.transport && flow_hit) begin
            st_next.transport = 1'b0;
        end

        // outside transport state a seal event wins over a lock in the same cycle
        if (seal_rise && !st_reg.transport) begin
            st_next.unlocked = 1'b1;
        end

        // module reading of the selected slot and reference
        // empty rather than stale when the slot cannot answer
        st_next.rd_val = EMPTY_READING;
        st_next.rd_empty = 1'b0;
        if (st_reg.sel_ref < REF_TYPE || st_reg.sel_ref > REF_LAST) begin
            st_next.rd_empty = 1'b1;
        end else if (!mod_present[st_reg.sel_slot]) begin
            st_next.rd_empty = (st_reg.sel_ref != REF_TYPE);
        end else if (!mod_comm_ok[st_reg.sel_slot]) begin
            st_next.rd_empty = 1'b1;
        // node id parts are shown in decimal, so each 16-bit part becomes bcd
        end else if (mod_type[st_reg.sel_slot] == NET_MODULE_TYPE &&
            st_reg.sel_ref >= REF_NODE0) begin
            st_next.rd_val = 32'(to_bcd(mod_node_id[st_reg.sel_slot][node_part*16 +: 16]));
        end else begin
            st_next.rd_val = mod_reading[st_reg.sel_slot][ref_idx];
        end

        // apb writes; read-only and unmapped offsets ignore a write
        if (wr_en && paddr == RATING_OFS) begin
            st_next.rating = pwdata[23:0];
        end
        if (wr_en && paddr == RSEL_OFS) begin
            st_next.sel_ref = pwdata[RSEL_REF_LSB +: 6];
            st_next.sel_slot = pwdata[RSEL_SLOT_LSB +: 2];
        end

        // apb read data prepared in the setup cycle
        if (rd_setup) begin
            st_next.pslverr = 1'b0;
            st_next.prdata = 32'h00000000;
            // any offset outside the map answers with an error and zero data
            unique case (paddr)
                CTRL_OFS: st_next.prdata = 32'h00000000;
                STATUS_OFS: st_next.prdata = {16'h0000, 1'b0, st_reg.item,
                    st_reg.menu, 3'b000, st_reg.saved, limit_locked, access_ok,
                    st_reg.unlocked, st_reg.transport};
                COUNT_OFS: st_next.prdata = 32'(st_reg.cfg_cnt);
                RATING_OFS: st_next.prdata = 32'(st_reg.rating);
                RSEL_OFS: st_next.prdata = {22'h000000, st_reg.sel_slot, 2'b00,
                    st_reg.sel_ref};
                RVAL_OFS: st_next.prdata = st_reg.rd_val;
                RSTAT_OFS: st_next.prdata = {30'h00000000,
                    mod_present[st_reg.sel_slot], st_reg.rd_empty};
                default: st_next.pslverr = 1'b1;
            endcase
        end
    end

    // state register, total reset returns to transport state
    // the reset branch loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.menu <= MENU_USER;
            st_reg.transport <= 1'b1;
            st_reg.cfg_cnt <= 6'h00;
            st_reg.rating <= RATING_RST;
            st_reg.sel_ref <= RSEL_REF_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // apb answer, every access completes without wait states
    assign pready = 1'b1;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;

    // display; the frames stay full while ok is shown, the hold being saturated
    assign menu_loop = st_reg.menu;
    assign setup_item = st_reg.item;
    assign frame_count = ((st_reg.menu == MENU_SETUP && st_reg.item == FINISH_ITEM) ||
        st_reg.menu == MENU_OK) ? frames(st_reg.hold) : 4'h0;
    assign show_ok = (st_reg.menu == MENU_OK);
    assign setup_access = access_ok;
    assign transport_state = st_reg.transport;
endmodule // sal_setup_access_lock

// [test_setup_access_lock_control.sv]
// self-checking bench for the setup access lock
// assumes a short menu tick so holds and timeouts stay brief
`timescale 1ns/1ps
module test_setup_access_lock_control
    import sal_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic primary_key, arrow_key, seal_reassembled, show_ok, setup_access, transport_state;
    logic [23:0] flow_rate;
    logic [3:0] mod_present, mod_comm_ok, frame_count;
    logic [3:0][7:0] mod_type;
    logic [3:0][5:0][31:0] mod_reading;
    logic [3:0][47:0] mod_node_id;
    logic [1:0] menu_loop;
    logic [4:0] setup_item;
    int n_errors = 0;
    int samples_checked = 0;
    sal_setup_access_lock #(.TICK_CYC(4)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .primary_key(primary_key),
        .arrow_key(arrow_key), .seal_reassembled(seal_reassembled), .flow_rate(flow_rate),
        .mod_present(mod_present), .mod_comm_ok(mod_comm_ok), .mod_type(mod_type),
        .mod_reading(mod_reading), .mod_node_id(mod_node_id), .menu_loop(menu_loop),
        .setup_item(setup_item), .frame_count(frame_count), .show_ok(show_ok),
        .setup_access(setup_access), .transport_state(transport_state));
    sal_panel_model panel (.pclk(pclk), .primary_key(primary_key), .arrow_key(arrow_key),
        .seal_reassembled(seal_reassembled));
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic close_out();
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, waiting for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            close_out();
        end else begin
            rv = prdata;
            ev = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rv, exp);
    endtask
    task automatic wait_menu(input logic [1:0] m, input int n);
        for (int i = 0; i < n && menu_loop !== m; i++) @(posedge pclk);
        if (menu_loop !== m) begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, flow_rate} = '0;
        {mod_type, mod_reading, mod_node_id} = '0;
        mod_present = 4'h6;
        mod_comm_ok = 4'h2;
        mod_type[1] = NET_MODULE_TYPE;
        mod_reading[1][2] = 32'h0BADF00D;
        mod_reading[0][0] = 32'h55AA55AA;
        mod_reading[2][1] = 32'h12345678;
        mod_node_id[1] = 48'h0000_0309_04D2;
        do_reset();
        check(transport_state, 1'b1);
        check(setup_access, 1'b1);
        rd(RATING_OFS, {8'h00, RATING_RST});
        // module readings by slot and reference
        apb(1'b1, RSEL_OFS, 32'h0000001F);
        rd(RVAL_OFS, EMPTY_READING);
        rd(RSTAT_OFS, 32'h0);
        apb(1'b1, RSEL_OFS, 32'h00000122);
        rd(RVAL_OFS, 32'h00001234);
        apb(1'b1, RSEL_OFS, 32'h00000123);
        rd(RVAL_OFS, 32'h00000777);
        apb(1'b1, RSEL_OFS, 32'h00000121);
        rd(RVAL_OFS, 32'h0BADF00D);
        apb(1'b1, RSEL_OFS, 32'h00000220);
        rd(RVAL_OFS, 32'h0);
        rd(RSTAT_OFS, 32'h3);
        apb(1'b0, 8'h40, 32'h0);
        check(ev, 1'b1);
        // transport: key exit after a save keeps access
        panel.enter();
        check(menu_loop, MENU_SETUP);
        apb(1'b1, CTRL_OFS, 32'h1);
        panel.leave();
        check(menu_loop, MENU_USER);
        check(setup_access, 1'b1);
        rd(COUNT_OFS, 32'h1);
        // transport: timeout keeps access
        panel.enter();
        repeat (9500) @(posedge pclk);
        check(menu_loop, MENU_SETUP);
        wait_menu(MENU_USER, 300);
        check(setup_access, 1'b1);
        rd(COUNT_OFS, 32'h1);
        // finish item: frames count up, ok, then locked
        panel.enter();
        for (int i = 0; i < 26 && setup_item !== FINISH_ITEM; i++) panel.step();
        fork
            panel.press(220);
            begin
                repeat (215) @(posedge pclk);
                check(show_ok, 1'b1);
                check(frame_count, 4'h8);
            end
        join
        check(transport_state, 1'b0);
        check(setup_access, 1'b0);
        // in operation: refused, then opened by the seal event
        panel.enter();
        check(menu_loop, MENU_TECH);
        panel.seal_event();
        panel.press(20);
        check(menu_loop, MENU_SETUP);
        apb(1'b1, CTRL_OFS, 32'h1);
        panel.leave();
        check(setup_access, 1'b0);
        rd(COUNT_OFS, 32'h2);
        // total reset, then the flow threshold
        do_reset();
        rd(COUNT_OFS, 32'h0);
        flow_rate <= 24'd9;
        repeat (8) @(posedge pclk);
        check(transport_state, 1'b1);
        flow_rate <= 24'd10;
        repeat (8) @(posedge pclk);
        flow_rate <= 24'd0;
        repeat (8) @(posedge pclk);
        check(transport_state, 1'b0);
        check(setup_access, 1'b0);
        // configuration limit in operation
        repeat (50) begin
            panel.seal_event();
            panel.enter();
            apb(1'b1, CTRL_OFS, 32'h1);
            panel.leave();
        end
        rd(COUNT_OFS, {26'h0, CFG_LIMIT});
        panel.seal_event();
        check(setup_access, 1'b0);
        panel.enter();
        check(menu_loop, MENU_TECH);
        do_reset();
        check(setup_access, 1'b1);
        close_out();
    end
endmodule // test_setup_access_lock_control
